// ---- mmp_cpu_model.sv ----
// CPU core model issuing one-cycle read and write strobes.
// Assumes the bench calls xfer from its falling-edge timeline.
`timescale 1ns/1ns
module mmp_cpu_model (
  input  logic        i_core_clk,
  output logic [15:0] o_addr,
  output logic        o_rd,
  output logic        o_wr,
  output logic [7:0]  o_wdata
);
  initial begin
    o_addr = 16'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h0;
  end
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
    @(negedge i_core_clk);
    o_addr = a;
    o_wdata = d;
    o_rd = ~w;
    o_wr = w;
    @(negedge i_core_clk);
    o_rd = 1'b0;
    o_wr = 1'b0;
    // Idle bus carries inverted values, not the last request
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

// ---- mmp_memory_map_port_regs.sv ----
// Address decoder for the 64 KB map and the zero-page port register bank.
// Assumes the CPU core presents address, strobes and data on i_core_clk and
// that port pins arrive asynchronously.
//
// Behaviour
// [R1] RAM 384 bytes above zero page
// [R2] FLASH 16384 bytes below first monitor ROM
// [R3] Top 48 bytes decode as vectors, except FFFF, which decodes as watchdog
// [R4] Monitor ROMs: 1024 and 448 bytes
// [R5] Unimplemented access requests reset when enabled
// [R6] Masters must not touch reserved locations
// [R7] Zero page 128 bytes holds I/O registers
// [R8] System registers FE00-FE0F, watchdog at FFFF
// [R9] Port data latches survive every reset
// [R10] Direction bits clear to zero on reset
// [R11] Port A top direction: power/low-voltage only
// [R12] Data widths 8,2,6,5; upper bits zero
// [R13] Narrow direction registers: upper bits zero
// [R14] Direction 1 drives latch; 0 reads pin; during i_srst a kept port A top bit drives 0
`timescale 1ns/1ns
module mmp_memory_map_port_regs (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_power_on_reset,
  input  wire logic        i_illegal_addr_en,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_port_a_pin,
  input  wire logic [1:0]  i_port_c_pin,
  input  wire logic [5:0]  i_port_d_pin,
  input  wire logic [4:0]  i_port_e_pin,
  output logic      [7:0]  o_rdata,
  output logic             o_rdata_valid,
  output logic             o_illegal_addr_reset,
  output logic      [3:0]  o_region,
  output logic             o_sel_ram,
  output logic             o_sel_flash,
  output logic             o_sel_mon,
  output logic             o_sel_sys,
  output logic             o_sel_wdog,
  output logic             o_sel_io_other,
  output logic      [7:0]  o_port_a_out,
  output logic      [7:0]  o_port_a_oe,
  output logic      [1:0]  o_port_c_out,
  output logic      [1:0]  o_port_c_oe,
  output logic      [5:0]  o_port_d_out,
  output logic      [5:0]  o_port_d_oe,
  output logic      [4:0]  o_port_e_out,
  output logic      [4:0]  o_port_e_oe
);

  function automatic mmp_pkg::mmp_region_type decode(input logic [15:0] a);
    logic [3:0] off;
    off = a[3:0];
    if (a <= mmp_pkg::IO_LAST)
      decode = mmp_pkg::REG_IO; // [R7]
    else if (a >= mmp_pkg::RAM_BASE && a <= mmp_pkg::RAM_LAST)
      decode = mmp_pkg::REG_RAM; // [R1]
    else if (a >= mmp_pkg::FLASH_BASE && a <= mmp_pkg::FLASH_LAST)
      decode = mmp_pkg::REG_FLASH; // [R2]
    else if (a >= mmp_pkg::MON1_BASE && a <= mmp_pkg::MON1_LAST)
      decode = mmp_pkg::REG_MON1; // [R4]
    else if (a >= mmp_pkg::SYS_BASE && a <= mmp_pkg::SYS_LAST)
      decode = mmp_pkg::SYS_RSVD_MAP[off] ? mmp_pkg::REG_RSVD
                                          : mmp_pkg::REG_SYS; // [R8]
    else if (a >= mmp_pkg::MON2_BASE && a <= mmp_pkg::MON2_LAST)
      decode = mmp_pkg::REG_MON2; // [R4]
    else if (a == mmp_pkg::WDOG_ADDR)
      decode = mmp_pkg::REG_WDOG; // [R8]
    else if (a >= mmp_pkg::VEC_BASE)
      decode = mmp_pkg::REG_VEC; // [R3]
    else
      decode = mmp_pkg::REG_NONE;
  endfunction

  // Layout of the packed pin vector, port A in the low byte
  // Widths match the port pins; positions follow from them
  localparam int PIN_A_W  = 8;
  localparam int PIN_C_W  = 2;
  localparam int PIN_D_W  = 6;
  localparam int PIN_E_W  = 5;
  localparam int PIN_C_LO = PIN_A_W;
  localparam int PIN_D_LO = PIN_C_LO + PIN_C_W;
  localparam int PIN_E_LO = PIN_D_LO + PIN_D_W;
  localparam int PIN_ALL  = PIN_E_LO + PIN_E_W;

  // Two-stage synchronisers for the pin levels
  logic [PIN_ALL-1:0] pin_meta_reg;
  logic [PIN_ALL-1:0] pin_sync_reg;
  always_ff @(posedge i_core_clk) begin
    pin_meta_reg <= {i_port_e_pin, i_port_d_pin, i_port_c_pin, i_port_a_pin};
    pin_sync_reg <= pin_meta_reg;
  end

  logic [7:0] pin_a;
  logic [7:0] pin_c;
  logic [7:0] pin_d;
  logic [7:0] pin_e;
  assign pin_a = pin_sync_reg[PIN_A_W-1:0];
  assign pin_c = {6'h00, pin_sync_reg[PIN_C_LO +: PIN_C_W]};
  assign pin_d = {2'h0, pin_sync_reg[PIN_D_LO +: PIN_D_W]};
  assign pin_e = {3'h0, pin_sync_reg[PIN_E_LO +: PIN_E_W]};

  mmp_pkg::mmp_region_type region;
  logic                    access;
  assign region = decode(i_addr);
  assign access = i_rd | i_wr;

  logic wr_a;
  logic wr_c;
  logic wr_d;
  logic wr_e;
  logic wr_da;
  logic wr_dc;
  logic wr_dd;
  logic wr_de;
  assign wr_a  = i_wr && i_addr == mmp_pkg::PORT_A_DATA;
  assign wr_c  = i_wr && i_addr == mmp_pkg::PORT_C_DATA;
  assign wr_d  = i_wr && i_addr == mmp_pkg::PORT_D_DATA;
  assign wr_e  = i_wr && i_addr == mmp_pkg::PORT_E_DATA;
  assign wr_da = i_wr && i_addr == mmp_pkg::PORT_A_DIR;
  assign wr_dc = i_wr && i_addr == mmp_pkg::PORT_C_DIR;
  assign wr_dd = i_wr && i_addr == mmp_pkg::PORT_D_DIR;
  assign wr_de = i_wr && i_addr == mmp_pkg::PORT_E_DIR;

  // Data latches: no reset term at all
  logic [7:0] port_a_data_reg;
  logic [7:0] port_c_data_reg;
  logic [7:0] port_d_data_reg;
  logic [7:0] port_e_data_reg;
  always_ff @(posedge i_core_clk) begin // [R9]
    if (wr_a)
      port_a_data_reg <= i_wdata & mmp_pkg::MASK_A; // [R12]
    if (wr_c)
      port_c_data_reg <= i_wdata & mmp_pkg::MASK_C; // [R12]
    if (wr_d)
      port_d_data_reg <= i_wdata & mmp_pkg::MASK_D; // [R12]
    if (wr_e)
      port_e_data_reg <= i_wdata & mmp_pkg::MASK_E; // [R12]
  end

  logic [7:0] port_a_direction_reg;
  logic [7:0] port_c_direction_reg;
  logic [7:0] port_d_direction_reg;
  logic [7:0] port_e_direction_reg;
  logic [7:0] port_a_direction_next;
  // Top bit of port A survives all but power-on and low-voltage reset
  always_comb begin
    port_a_direction_next = port_a_direction_reg;
    if (i_power_on_reset)
      port_a_direction_next = mmp_pkg::DIR_RESET; // [R11]
    else if (i_srst)
      port_a_direction_next = port_a_direction_reg
                              & mmp_pkg::DIR_A_KEEP; // [R10] [R11]
    else if (wr_da)
      port_a_direction_next = i_wdata & mmp_pkg::MASK_A;
  end

  always_ff @(posedge i_core_clk) begin
    port_a_direction_reg <= port_a_direction_next;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_power_on_reset) begin
      port_c_direction_reg <= mmp_pkg::DIR_RESET; // [R10]
      port_d_direction_reg <= mmp_pkg::DIR_RESET; // [R10]
      port_e_direction_reg <= mmp_pkg::DIR_RESET; // [R10]
    end else begin
      if (wr_dc)
        port_c_direction_reg <= i_wdata & mmp_pkg::MASK_C; // [R13]
      if (wr_dd)
        port_d_direction_reg <= i_wdata & mmp_pkg::MASK_D; // [R13]
      if (wr_de)
        port_e_direction_reg <= i_wdata & mmp_pkg::MASK_E; // [R13]
    end
  end

  // Mixed read: output bits show the latch, input bits show the pin
  function automatic logic [7:0] mix(input logic [7:0] dir,
                                     input logic [7:0] lat,
                                     input logic [7:0] pin);
    mix = (dir & lat) | (~dir & pin);
  endfunction

  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    case (i_addr)
      mmp_pkg::PORT_A_DATA:
        rdata_next = mix(port_a_direction_reg, port_a_data_reg, pin_a); // [R14]
      mmp_pkg::PORT_C_DATA:
        rdata_next = mix(port_c_direction_reg, port_c_data_reg, pin_c)
                     & mmp_pkg::MASK_C; // [R12]
      mmp_pkg::PORT_D_DATA:
        rdata_next = mix(port_d_direction_reg, port_d_data_reg, pin_d)
                     & mmp_pkg::MASK_D; // [R12]
      mmp_pkg::PORT_E_DATA:
        rdata_next = mix(port_e_direction_reg, port_e_data_reg, pin_e)
                     & mmp_pkg::MASK_E; // [R12]
      mmp_pkg::PORT_A_DIR: rdata_next = port_a_direction_reg;
      mmp_pkg::PORT_C_DIR: rdata_next = port_c_direction_reg; // [R13]
      mmp_pkg::PORT_D_DIR: rdata_next = port_d_direction_reg; // [R13]
      mmp_pkg::PORT_E_DIR: rdata_next = port_e_direction_reg; // [R13]
      default: rdata_next = 8'h00;
    endcase
  end

  logic port_hit;
  assign port_hit = i_addr <= mmp_pkg::PORT_E_DIR
                    && i_addr != mmp_pkg::RSVD_01
                    && i_addr != mmp_pkg::RSVD_05;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata       <= (i_rd && port_hit) ? rdata_next : 8'h00;
      o_rdata_valid <= i_rd && port_hit;
    end
  end

  // Region code follows the address on every cycle, access or not
  always_ff @(posedge i_core_clk) begin
    if (i_srst)
      o_region <= 4'(mmp_pkg::REG_NONE);
    else
      o_region <= 4'(region);
  end

  // Region strobes, registered one cycle after the access
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_sel_ram            <= 1'b0;
      o_sel_flash          <= 1'b0;
      o_sel_mon            <= 1'b0;
      o_sel_sys            <= 1'b0;
      o_sel_wdog           <= 1'b0;
      o_sel_io_other       <= 1'b0;
      o_illegal_addr_reset <= 1'b0;
    end else begin
      o_sel_ram      <= access && region == mmp_pkg::REG_RAM; // [R1]
      o_sel_flash    <= access && (region == mmp_pkg::REG_FLASH
                        || region == mmp_pkg::REG_VEC); // [R2] [R3]
      o_sel_mon      <= access && (region == mmp_pkg::REG_MON1
                        || region == mmp_pkg::REG_MON2); // [R4]
      o_sel_sys      <= access && region == mmp_pkg::REG_SYS; // [R8]
      o_sel_wdog     <= access && region == mmp_pkg::REG_WDOG; // [R8]
      o_sel_io_other <= access && region == mmp_pkg::REG_IO
                        && i_addr > mmp_pkg::PORT_E_DIR; // [R7]
      o_illegal_addr_reset <= access && i_illegal_addr_en
                              && region == mmp_pkg::REG_NONE; // [R5]
    end
  end

  // Port A drive follows the next direction value, so a top direction bit
  // kept through a plain reset goes on driving its pin during that reset
  always_ff @(posedge i_core_clk) begin // [R11] [R14]
    o_port_a_oe <= port_a_direction_next;
  end

  always_ff @(posedge i_core_clk) begin // [R14]
    if (i_srst)
      o_port_a_out <= 8'h00;
    else
      o_port_a_out <= port_a_data_reg;
  end

  // Narrow ports drop drive and latch view on i_srst; power-on reset alone drops drive only, one cycle later
  always_ff @(posedge i_core_clk) begin // [R14]
    if (i_srst) begin
      o_port_c_out <= 2'h0;
      o_port_c_oe  <= 2'h0;
    end else begin
      o_port_c_out <= port_c_data_reg[1:0];
      o_port_c_oe  <= port_c_direction_reg[1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin // [R14]
    if (i_srst) begin
      o_port_d_out <= 6'h00;
      o_port_d_oe  <= 6'h00;
    end else begin
      o_port_d_out <= port_d_data_reg[5:0];
      o_port_d_oe  <= port_d_direction_reg[5:0];
    end
  end

  always_ff @(posedge i_core_clk) begin // [R14]
    if (i_srst) begin
      o_port_e_out <= 5'h00;
      o_port_e_oe  <= 5'h00;
    end else begin
      o_port_e_out <= port_e_data_reg[4:0];
      o_port_e_oe  <= port_e_direction_reg[4:0];
    end
  end

endmodule

// ---- mmp_memory_map_port_regs_tb.sv ----
// Bench for the address decoder and port register bank.
// Assumes the CPU model drives the bus; pins change at the falling edge.
`timescale 1ns/1ns
module mmp_memory_map_port_regs_tb;
  localparam logic [7:0]  MSK [4] = '{8'hff, 8'h03, 8'h3f, 8'h1f};
  localparam logic [15:0] DA [4] = '{16'h0, 16'h2, 16'h3, 16'h8};
  localparam logic [15:0] DD [4] = '{16'h4, 16'h6, 16'h7, 16'h9};
  localparam logic [15:0] CA [17] = '{16'h0080, 16'h01ff, 16'h0200,
    16'hb9ff, 16'hba00, 16'hf9ff, 16'hfa00, 16'hfdff, 16'hfe00, 16'hfe0e,
    16'hfe10, 16'hffcf, 16'hffd0, 16'hffff, 16'h007f, 16'h000a, 16'h0009};
  logic        i_core_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_power_on_reset = 1'b1;
  logic        i_illegal_addr_en = 1'b1;
  wire  [15:0] i_addr;
  wire         i_rd;
  wire         i_wr;
  wire  [7:0]  i_wdata;
  wire  [7:0]  o_rdata;
  wire  [7:0]  sel;
  wire  [3:0]  reg_code;
  wire  [7:0]  oe [4];
  wire  [7:0]  out [4];
  logic [7:0]  pin [4];
  logic [7:0]  lat [4];
  logic [7:0]  dir [4];
  logic [15:0] a;
  int          seed = 32'h46cb;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  int          k;
  mmp_cpu_model u_mmp_cpu_model (.i_core_clk, .o_addr(i_addr),
    .o_rd(i_rd), .o_wr(i_wr), .o_wdata(i_wdata));
  mmp_memory_map_port_regs u_mmp_memory_map_port_regs (.i_core_clk,
    .i_srst, .i_power_on_reset, .i_illegal_addr_en, .i_addr, .i_rd, .i_wr,
    .i_wdata, .i_port_a_pin(pin[0]), .i_port_c_pin(pin[1][1:0]),
    .i_port_d_pin(pin[2][5:0]), .i_port_e_pin(pin[3][4:0]), .o_rdata,
    .o_rdata_valid(sel[7]), .o_illegal_addr_reset(sel[6]),
    .o_region(reg_code),
    .o_sel_ram(sel[0]), .o_sel_flash(sel[1]), .o_sel_mon(sel[2]),
    .o_sel_sys(sel[3]), .o_sel_wdog(sel[4]), .o_sel_io_other(sel[5]),
    .o_port_a_out(out[0]), .o_port_a_oe(oe[0]), .o_port_c_out(out[1][1:0]),
    .o_port_c_oe(oe[1][1:0]), .o_port_d_out(out[2][5:0]),
    .o_port_d_oe(oe[2][5:0]), .o_port_e_out(out[3][4:0]),
    .o_port_e_oe(oe[3][4:0]));
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [15:0] ad, input logic [7:0] e);
    u_mmp_cpu_model.xfer(1'b0, ad, 8'h00);
    chk(o_rdata, e);
  endtask
  task automatic pulse_rst(input logic por);
    i_srst = 1'b1;
    i_power_on_reset = por;
    repeat (2) @(negedge i_core_clk);
    i_srst = 1'b0;
    i_power_on_reset = 1'b0;
  endtask
  function automatic logic [7:0] exp_rd(int j);
    return (lat[j] & dir[j] | pin[j] & ~dir[j]) & MSK[j];
  endfunction
  function automatic logic [7:0] exp_sel(logic [15:0] x);
    return {x < 16'h000a && x != 16'h0001 && x != 16'h0005,
      i_illegal_addr_en && x inside {[16'h0200:16'hb9ff]},
      x inside {[16'h000a:16'h007f]}, x == 16'hffff,
      x inside {[16'hfe00:16'hfe0f]},
      x inside {[16'hfa00:16'hfdff], [16'hfe10:16'hffcf]},
      x inside {[16'hba00:16'hf9ff], [16'hffd0:16'hfffe]},
      x inside {[16'h0080:16'h01ff]}};
  endfunction
  function automatic logic [7:0] exp_reg(logic [15:0] x);
    mmp_pkg::mmp_region_type r;
    r = mmp_pkg::REG_NONE;
    if (x inside {[16'h0000:16'h007f]})
      r = mmp_pkg::REG_IO;
    else if (x inside {[16'h0080:16'h01ff]})
      r = mmp_pkg::REG_RAM;
    else if (x inside {[16'hba00:16'hf9ff]})
      r = mmp_pkg::REG_FLASH;
    else if (x inside {[16'hfa00:16'hfdff]})
      r = mmp_pkg::REG_MON1;
    else if (x inside {[16'hfe00:16'hfe0f]})
      r = mmp_pkg::REG_SYS;
    else if (x inside {[16'hfe10:16'hffcf]})
      r = mmp_pkg::REG_MON2;
    else if (x == 16'hffff)
      r = mmp_pkg::REG_WDOG;
    else if (x >= 16'hffd0)
      r = mmp_pkg::REG_VEC;
    return {4'h0, 4'(r)};
  endfunction
  initial begin
    pin = '{default: 8'h00};
    repeat (16) @(negedge i_core_clk);
    i_srst = 1'b0;
    i_power_on_reset = 1'b0;
    for (k = 0; k < 4; k++) begin
      rd_chk(DD[k], 8'h00);
      chk(oe[k] & MSK[k], 8'h00);
    end
    for (int n = 0; n < 48; n++) begin
      k = n < 4 ? n : $unsigned($random(seed)) % 4;
      pin[k] = 8'($random(seed));
      dir[k] = n % 8 == 5 ? 8'h00 : n % 8 == 6 ? 8'hff : 8'($random(seed));
      lat[k] = 8'($random(seed));
      u_mmp_cpu_model.xfer(1'b1, DD[k], dir[k]);
      u_mmp_cpu_model.xfer(1'b1, DA[k], lat[k]);
      @(negedge i_core_clk);
      chk(oe[k] & MSK[k], dir[k] & MSK[k]);
      chk(out[k] & MSK[k], lat[k] & MSK[k]);
      rd_chk(DA[k], exp_rd(k));
      rd_chk(DD[k], dir[k] & MSK[k]);
    end
    for (int n = 0; n < 57; n++) begin
      a = n < 17 ? CA[n] : 16'($random(seed));
      while (a inside {16'h0001, 16'h0005, 16'hfe02, 16'hfe06, 16'hfe07,
                       16'hfe0a, 16'hfe0b, 16'hfe0f})
        a++;
      i_illegal_addr_en = 1'($random(seed));
      u_mmp_cpu_model.xfer(1'b0, a, 8'h00);
      chk(sel, exp_sel(a));
      chk({4'h0, reg_code}, exp_reg(a));
    end
    for (k = 0; k < 4; k++)
      u_mmp_cpu_model.xfer(1'b1, DD[k], 8'hff);
    pulse_rst(1'b0);
    chk(oe[0], 8'h80);
    for (k = 0; k < 4; k++) begin
      rd_chk(DD[k], k == 0 ? 8'h80 : 8'h00);
      u_mmp_cpu_model.xfer(1'b1, DD[k], 8'hff);
      rd_chk(DA[k], lat[k] & MSK[k]);
    end
    pulse_rst(1'b1);
    rd_chk(DD[0], 8'h00);
    report_and_stop();
  end
endmodule

// ---- mmp_pkg.sv ----
// Package for the memory map decoder and parallel port register bank.
// Assumes a 16-bit CPU address bus and 8-bit data on one system clock.
package mmp_pkg;
  // Region boundaries
  localparam logic [15:0] IO_BASE      = 16'h0000;
  localparam logic [15:0] IO_LAST      = 16'h007f;
  localparam logic [15:0] RAM_BASE     = 16'h0080;
  localparam logic [15:0] RAM_LAST     = 16'h01ff;
  localparam logic [15:0] FLASH_BASE   = 16'hba00;
  localparam logic [15:0] FLASH_LAST   = 16'hf9ff;
  localparam logic [15:0] MON1_BASE    = 16'hfa00;
  localparam logic [15:0] MON1_LAST    = 16'hfdff;
  localparam logic [15:0] SYS_BASE     = 16'hfe00;
  localparam logic [15:0] SYS_LAST     = 16'hfe0f;
  localparam logic [15:0] MON2_BASE    = 16'hfe10;
  localparam logic [15:0] MON2_LAST    = 16'hffcf;
  localparam logic [15:0] VEC_BASE     = 16'hffd0;
  localparam logic [15:0] VEC_LAST     = 16'hffff;
  localparam logic [15:0] WDOG_ADDR    = 16'hffff;
  // Reserved system register locations, one bit per offset 0..15
  localparam logic [15:0] SYS_RSVD_MAP = 16'h8cc4;

  // Port register offsets
  localparam logic [15:0] PORT_A_DATA  = 16'h0000;
  localparam logic [15:0] RSVD_01      = 16'h0001;
  localparam logic [15:0] PORT_C_DATA  = 16'h0002;
  localparam logic [15:0] PORT_D_DATA  = 16'h0003;
  localparam logic [15:0] PORT_A_DIR   = 16'h0004;
  localparam logic [15:0] RSVD_05      = 16'h0005;
  localparam logic [15:0] PORT_C_DIR   = 16'h0006;
  localparam logic [15:0] PORT_D_DIR   = 16'h0007;
  localparam logic [15:0] PORT_E_DATA  = 16'h0008;
  localparam logic [15:0] PORT_E_DIR   = 16'h0009;

  // Implemented bit masks
  localparam logic [7:0] MASK_A        = 8'hff;
  localparam logic [7:0] MASK_C        = 8'h03;
  localparam logic [7:0] MASK_D        = 8'h3f;
  localparam logic [7:0] MASK_E        = 8'h1f;
  localparam logic [7:0] DIR_RESET     = 8'h00;
  localparam logic [7:0] DIR_A_KEEP    = 8'h80;

  typedef enum logic [3:0] {
    REG_IO, REG_RAM, REG_FLASH, REG_MON1, REG_SYS, REG_MON2,
    REG_VEC, REG_WDOG, REG_RSVD, REG_NONE
  } mmp_region_type;
endpackage

// ---- mmp_props.sv ----
// Checker for the address decoder and port register bank.
// Assumes it is bound to the top module; one clock, sync reset.
`timescale 1ns/1ns
module mmp_props (
  input logic        i_core_clk,
  input logic        i_srst,
  input logic        i_power_on_reset,
  input logic        i_illegal_addr_en,
  input logic [15:0] i_addr,
  input logic        i_rd,
  input logic        i_wr,
  input logic        o_rdata_valid,
  input logic        o_illegal_addr_reset,
  input logic        o_sel_ram,
  input logic        o_sel_flash,
  input logic        o_sel_mon,
  input logic        o_sel_wdog,
  input logic        o_sel_io_other,
  input logic [7:0]  o_port_a_oe,
  input logic [1:0]  o_port_c_oe,
  input logic [5:0]  o_port_d_oe,
  input logic [4:0]  o_port_e_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic acc;
  assign acc = i_rd | i_wr;
  ram_sel_a: assert property (
    o_sel_ram == $past(acc && i_addr inside {[16'h0080:16'h01ff]}))
    else $error("ram select wrong");
  flash_sel_a: assert property (
    o_sel_flash == $past(acc && i_addr inside
      {[16'hba00:16'hf9ff], [16'hffd0:16'hfffe]}))
    else $error("flash select wrong");
  mon_sel_a: assert property (
    o_sel_mon == $past(acc && i_addr inside
      {[16'hfa00:16'hfdff], [16'hfe10:16'hffcf]}))
    else $error("monitor select wrong");
  wdog_sel_a: assert property (
    o_sel_wdog == $past(acc && i_addr == 16'hffff))
    else $error("watchdog select wrong");
  io_sel_a: assert property (
    o_sel_io_other == $past(acc && i_addr inside {[16'h000a:16'h007f]}))
    else $error("zero page select wrong");
  illegal_req_a: assert property (
    o_illegal_addr_reset == $past(acc && i_illegal_addr_en
      && i_addr inside {[16'h0200:16'hb9ff]}))
    else $error("illegal address request wrong");
  read_valid_a: assert property (
    o_rdata_valid == $past(i_rd && i_addr < 16'h000a
      && i_addr != 16'h0001 && i_addr != 16'h0005))
    else $error("read valid wrong");
  dir_clear_a: assert property (disable iff (1'b0)
    i_srst ##1 !i_srst && !i_wr |=> o_port_c_oe == 2'h0
      && o_port_d_oe == 6'h0 && o_port_e_oe == 5'h0
      && o_port_a_oe[6:0] == 7'h0)
    else $error("direction not cleared");
  por_clear_a: assert property (disable iff (1'b0)
    i_power_on_reset ##1 i_power_on_reset |=> o_port_a_oe == 8'h0)
    else $error("top direction bit not cleared");
endmodule
bind mmp_memory_map_port_regs mmp_props u_mmp_props (.i_core_clk, .i_srst,
  .i_power_on_reset, .i_illegal_addr_en, .i_addr, .i_rd, .i_wr,
  .o_rdata_valid, .o_illegal_addr_reset, .o_sel_ram, .o_sel_flash,
  .o_sel_mon, .o_sel_wdog, .o_sel_io_other, .o_port_a_oe, .o_port_c_oe,
  .o_port_d_oe, .o_port_e_oe);
